// ===== core/arogc_cal_bank.sv
// calibration register bank with apb slave and result correction path
//
// Summary of operation
// (R1) high-speed results get their own offset trim
// (R2) offset is two's complement, quarter lsb steps
// (R3) 0x3FFF is +4095.75, 0x0001 is +0.25
// (R4) 0x4000 gives most negative, -4096.0
// (R5) 0x7FFF is -0.25; zero leaves result
// (R6) high-speed results scaled by gain trim
// (R7) gain 0x4000 is exactly one, reset value
// (R8) gain 0x7FFF gives nearly two
// (R9) gain 0x2000 halves the result
// (R10) gain step is two to minus fourteen
// (R11) gain zero forces result to zero
// (R12) aux unity-gain results get separate offset
// (R13) gain bit 14 weighted unity, rest fraction
// (R14) trims writable only after unlock key
// (R15) bits 31 to 15 read zero
`timescale 1ns/100ps
`default_nettype none
module arogc_cal_bank
  import arogc_pkg::*;
#(
  parameter int unsigned W = arogc_pkg::WORD_W
) (
  // clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // apb slave
  input  wire logic [arogc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [arogc_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [arogc_pkg::STRB_W-1:0]  pstrb,
  output logic [arogc_pkg::DATA_W-1:0]       prdata,
  output logic                               pready,
  output logic                               pslverr,
  // raw conversion results
  input  wire logic                          conv_valid,
  input  wire logic [W-1:0]                  conversion_result_word,
  input  wire arogc_pkg::arogc_chan_t        conv_channel,
  // corrected results
  output logic                               corrected_valid,
  output logic [W-1:0]                       corrected_word,
  // lock state
  output logic                               cal_unlocked
);

  import arogc_pkg::*;

  logic [DATA_W-1:0]  write_lock_ff;
  logic [FIELD_W-1:0] hs_channel_offset_trim_ff;
  logic [FIELD_W-1:0] aux_unity_gain_offset_trim_ff;
  logic [FIELD_W-1:0] hs_channel_gain_trim_ff;
  logic [DATA_W-1:0]  prdata_ff;
  logic [W-1:0]       last_word_ff;
  logic [DATA_W-1:0]  wmask;
  logic [DATA_W-1:0]  nxt_prdata;
  logic [FIELD_W-1:0] nxt_field;
  logic [FIELD_W-1:0] sel_offset;
  logic [FIELD_W-1:0] sel_gain;
  logic               hit;
  logic               wr_en;
  logic               rd_setup;
  logic               unlocked;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  // zero wait states: every access completes in its first access cycle
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  always_comb begin
    if (paddr == ADDR_WRITE_LOCK) begin
      hit = 1'b1;
    end else if (paddr == ADDR_HS_OFFSET_TRIM) begin
      hit = 1'b1;
    end else if (paddr == ADDR_AUX_OFFSET_TRIM) begin
      hit = 1'b1;
    end else if (paddr == ADDR_HS_GAIN_TRIM) begin
      hit = 1'b1;
    end else if (paddr == ADDR_CAL_STATUS) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  assign pslverr = psel & penable & ~hit;

  // byte lane mask from the write strobes
  for (genvar i = 0; i < STRB_W; i++) begin : g_lane
    assign wmask[8*i +: 8] = {8{pstrb[i]}};
  end

  // ---------------------------------------------------------------
  // lock key
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_lock_ff <= RST_WRITE_LOCK;
    end else if (wr_en && paddr == ADDR_WRITE_LOCK) begin
      write_lock_ff <= (write_lock_ff & ~wmask) | (pwdata & wmask);
    end
  end

  assign unlocked     = (write_lock_ff == UNLOCK_KEY); // R14
  assign cal_unlocked = unlocked;

  // ---------------------------------------------------------------
  // trim registers
  // ---------------------------------------------------------------
  // only the low field is stored, so upper bits can never be written
  assign nxt_field = (pwdata[FIELD_W-1:0] & wmask[FIELD_W-1:0]); // R15

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_channel_offset_trim_ff <= RST_OFFSET_TRIM;
    end else if (wr_en && unlocked && paddr == ADDR_HS_OFFSET_TRIM) begin // R14
      hs_channel_offset_trim_ff <= (hs_channel_offset_trim_ff & ~wmask[FIELD_W-1:0]) | nxt_field; // R1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_unity_gain_offset_trim_ff <= RST_OFFSET_TRIM;
    end else if (wr_en && unlocked && paddr == ADDR_AUX_OFFSET_TRIM) begin // R14
      aux_unity_gain_offset_trim_ff <= (aux_unity_gain_offset_trim_ff & ~wmask[FIELD_W-1:0]) | nxt_field; // R12
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_channel_gain_trim_ff <= RST_GAIN_TRIM; // R7
    end else if (wr_en && unlocked && paddr == ADDR_HS_GAIN_TRIM) begin // R14
      hs_channel_gain_trim_ff <= (hs_channel_gain_trim_ff & ~wmask[FIELD_W-1:0]) | nxt_field; // R6
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // read data is captured in the setup cycle so prdata comes straight from a flop
  always_comb begin
    nxt_prdata = '0;
    if (paddr == ADDR_WRITE_LOCK) begin
      nxt_prdata = write_lock_ff;
    end else if (paddr == ADDR_HS_OFFSET_TRIM) begin
      nxt_prdata[FIELD_W-1:0] = hs_channel_offset_trim_ff; // R15
    end else if (paddr == ADDR_AUX_OFFSET_TRIM) begin
      nxt_prdata[FIELD_W-1:0] = aux_unity_gain_offset_trim_ff; // R15
    end else if (paddr == ADDR_HS_GAIN_TRIM) begin
      nxt_prdata[FIELD_W-1:0] = hs_channel_gain_trim_ff; // R15
    end else if (paddr == ADDR_CAL_STATUS) begin
      nxt_prdata[STAT_UNLOCKED_BIT]          = unlocked;
      nxt_prdata[STAT_LAST_LSB +: WORD_W]    = last_word_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
    end else if (rd_setup) begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = prdata_ff;

  // ---------------------------------------------------------------
  // coefficient selection
  // ---------------------------------------------------------------
  // channels without a trim here pass through: no offset and unity gain
  always_comb begin
    case (conv_channel)
      CHAN_HS_TIA: begin
        sel_offset = hs_channel_offset_trim_ff; // R1
        sel_gain   = hs_channel_gain_trim_ff; // R6
      end
      CHAN_AUX_GAIN1: begin
        sel_offset = aux_unity_gain_offset_trim_ff; // R12
        sel_gain   = GAIN_UNITY;
      end
      default: begin
        sel_offset = OFFSET_NONE;
        sel_gain   = GAIN_UNITY;
      end
    endcase
  end

  arogc_corrector #(
    .W (W)
  ) u_corrector (
    .pclk      (pclk),
    .presetn   (presetn),
    .raw_valid   (conv_valid),
    .raw_word    (conversion_result_word),
    .offset_trim (sel_offset),
    .gain_trim   (sel_gain),
    .corr_valid  (corrected_valid),
    .corr_word   (corrected_word)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_word_ff <= '0;
    end else if (corrected_valid) begin
      last_word_ff <= corrected_word;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_locked_write_held: assert property ( // R14
    @(posedge pclk) disable iff (!presetn)
    (wr_en && !unlocked && paddr == ADDR_HS_GAIN_TRIM) |=> $stable(hs_channel_gain_trim_ff))
    else $error("gain trim changed while locked");

  a_unlocked_write_takes: assert property ( // R6
    @(posedge pclk) disable iff (!presetn)
    (wr_en && unlocked && paddr == ADDR_HS_GAIN_TRIM && pstrb == 4'hF)
      |=> (hs_channel_gain_trim_ff == $past(pwdata[FIELD_W-1:0])))
    else $error("unlocked gain trim write lost");

  a_reserved_read_zero: assert property ( // R15
    @(posedge pclk) disable iff (!presetn)
    (rd_setup && (paddr == ADDR_HS_OFFSET_TRIM || paddr == ADDR_HS_GAIN_TRIM || paddr == ADDR_AUX_OFFSET_TRIM))
      |=> (prdata[DATA_W-1:FIELD_W] == '0))
    else $error("reserved trim bits read nonzero");

  a_result_latency: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    conv_valid |-> ##2 corrected_valid)
    else $error("corrected result not two cycles after input");

  a_gain_zero_out: assert property ( // R11
    @(posedge pclk) disable iff (!presetn)
    (conv_valid && conv_channel == CHAN_HS_TIA && hs_channel_gain_trim_ff == GAIN_ILLEGAL)
      |-> ##2 (corrected_word == WORD_MIN))
    else $error("zero gain did not clear result");

  a_unity_passthru: assert property ( // R7 R5
    @(posedge pclk) disable iff (!presetn)
    (conv_valid && conv_channel == CHAN_HS_TIA && hs_channel_gain_trim_ff == GAIN_UNITY
      && hs_channel_offset_trim_ff == OFFSET_NONE)
      |-> ##2 (corrected_word == $past(conversion_result_word, 2)))
    else $error("unity gain changed the result");

  a_half_gain: assert property ( // R9
    @(posedge pclk) disable iff (!presetn)
    (conv_valid && conv_channel == CHAN_HS_TIA && hs_channel_gain_trim_ff == 15'h2000
      && hs_channel_offset_trim_ff == OFFSET_NONE)
      |-> ##2 ({1'b0, corrected_word} == ({1'b0, $past(conversion_result_word, 2)} + 17'h00001) >> 1))
    else $error("half gain result wrong");

  a_max_neg_offset: assert property ( // R4 R2
    @(posedge pclk) disable iff (!presetn)
    (conv_valid && conv_channel == CHAN_HS_TIA && hs_channel_gain_trim_ff == GAIN_UNITY
      && hs_channel_offset_trim_ff == 15'h4000 && conversion_result_word >= 16'h1000)
      |-> ##2 (corrected_word == $past(conversion_result_word, 2) - 16'h1000))
    else $error("most negative offset wrong");

  a_aux_offset_step: assert property ( // R12 R3
    @(posedge pclk) disable iff (!presetn)
    (conv_valid && conv_channel == CHAN_AUX_GAIN1 && aux_unity_gain_offset_trim_ff == 15'h0004
      && conversion_result_word != WORD_MAX)
      |-> ##2 (corrected_word == $past(conversion_result_word, 2) + 16'h0001))
    else $error("aux offset of one lsb wrong");

  a_other_passthru: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    (conv_valid && conv_channel == CHAN_OTHER)
      |-> ##2 (corrected_word == $past(conversion_result_word, 2)))
    else $error("uncalibrated channel altered");

  a_hs_offset_held: assert property ( // R14
    @(posedge pclk) disable iff (!presetn)
    (wr_en && !unlocked && paddr == ADDR_HS_OFFSET_TRIM) |=> $stable(hs_channel_offset_trim_ff))
    else $error("offset trim changed while locked");

  a_aux_offset_held: assert property ( // R14
    @(posedge pclk) disable iff (!presetn)
    (wr_en && !unlocked && paddr == ADDR_AUX_OFFSET_TRIM) |=> $stable(aux_unity_gain_offset_trim_ff))
    else $error("aux offset trim changed while locked");

  a_hs_offset_takes: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    (wr_en && unlocked && paddr == ADDR_HS_OFFSET_TRIM && pstrb == 4'hF)
      |=> (hs_channel_offset_trim_ff == $past(pwdata[FIELD_W-1:0])))
    else $error("unlocked offset trim write lost");

  a_aux_offset_takes: assert property ( // R12
    @(posedge pclk) disable iff (!presetn)
    (wr_en && unlocked && paddr == ADDR_AUX_OFFSET_TRIM && pstrb == 4'hF)
      |=> (aux_unity_gain_offset_trim_ff == $past(pwdata[FIELD_W-1:0])))
    else $error("unlocked aux offset trim write lost");

  a_key_unlocks: assert property ( // R14
    @(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_WRITE_LOCK && pstrb == 4'hF && pwdata == UNLOCK_KEY) |=> cal_unlocked)
    else $error("key write did not unlock");

  a_wrong_key_locks: assert property ( // R14
    @(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_WRITE_LOCK && pstrb == 4'hF && pwdata != UNLOCK_KEY) |=> !cal_unlocked)
    else $error("wrong key left trims unlocked");

  a_status_lock_bit: assert property ( // R14
    @(posedge pclk) disable iff (!presetn)
    (rd_setup && paddr == ADDR_CAL_STATUS) |=> (prdata[STAT_UNLOCKED_BIT] == $past(unlocked)))
    else $error("status lock bit wrong");

  a_max_pos_offset: assert property ( // R3
    @(posedge pclk) disable iff (!presetn)
    (conv_valid && conv_channel == CHAN_HS_TIA && hs_channel_gain_trim_ff == GAIN_UNITY
      && hs_channel_offset_trim_ff == 15'h3FFF && conversion_result_word <= 16'hEFFF)
      |-> ##2 (corrected_word == $past(conversion_result_word, 2) + 16'h1000))
    else $error("most positive offset wrong");

  a_quarter_offset: assert property ( // R5 R3
    @(posedge pclk) disable iff (!presetn)
    (conv_valid && conv_channel == CHAN_HS_TIA && hs_channel_gain_trim_ff == GAIN_UNITY
      && (hs_channel_offset_trim_ff == 15'h7FFF || hs_channel_offset_trim_ff == 15'h0001))
      |-> ##2 (corrected_word == $past(conversion_result_word, 2)))
    else $error("quarter lsb offset did not round back");

  a_max_gain_double: assert property ( // R8
    @(posedge pclk) disable iff (!presetn)
    (conv_valid && conv_channel == CHAN_HS_TIA && hs_channel_gain_trim_ff == 15'h7FFF
      && hs_channel_offset_trim_ff == OFFSET_NONE && conversion_result_word <= 16'h2000)
      |-> ##2 (corrected_word == ($past(conversion_result_word, 2) << 1)))
    else $error("largest gain did not double");

  a_gain_clamp_top: assert property ( // R8
    @(posedge pclk) disable iff (!presetn)
    (conv_valid && conv_channel == CHAN_HS_TIA && hs_channel_gain_trim_ff == 15'h7FFF
      && hs_channel_offset_trim_ff == OFFSET_NONE && conversion_result_word >= 16'h8002)
      |-> ##2 (corrected_word == WORD_MAX))
    else $error("overflowing result not clamped");

endmodule
`default_nettype wire

// ===== core/arogc_pkg.sv
// shared constants and types for the conversion result calibration register bank
package arogc_pkg;

  // ---------------------------------------------------------------
  // bus and field widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned STRB_W    = DATA_W / 8;
  localparam int unsigned FIELD_W   = 15;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned FRAC_OFF  = 2;
  localparam int unsigned FRAC_GAIN = 14;
  localparam int unsigned SUM_W     = WORD_W + FRAC_OFF + 2;
  localparam int unsigned PROD_W    = SUM_W + FIELD_W + 1;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_WRITE_LOCK      = 16'h2230;
  localparam logic [ADDR_W-1:0] ADDR_HS_OFFSET_TRIM  = 16'h2234;
  localparam logic [ADDR_W-1:0] ADDR_AUX_OFFSET_TRIM = 16'h2244;
  localparam logic [ADDR_W-1:0] ADDR_HS_GAIN_TRIM    = 16'h2284;
  localparam logic [ADDR_W-1:0] ADDR_CAL_STATUS      = 16'h22F0;

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0]  RST_WRITE_LOCK  = 32'h0000_0000;
  localparam logic [FIELD_W-1:0] RST_OFFSET_TRIM = 15'h0000;
  localparam logic [FIELD_W-1:0] RST_GAIN_TRIM   = 15'h4000;
  localparam logic [FIELD_W-1:0] GAIN_UNITY      = 15'h4000;
  localparam logic [FIELD_W-1:0] GAIN_ILLEGAL    = 15'h0000;
  localparam logic [FIELD_W-1:0] OFFSET_NONE     = 15'h0000;
  localparam logic [DATA_W-1:0]  UNLOCK_KEY      = 32'hDE87_A5AF;
  localparam logic [WORD_W-1:0]  WORD_MAX        = 16'hFFFF;
  localparam logic [WORD_W-1:0]  WORD_MIN        = 16'h0000;
  localparam logic [PROD_W-1:0]  ROUND_HALF      = 36'h0_0000_8000;

  // ---------------------------------------------------------------
  // status register fields
  // ---------------------------------------------------------------
  localparam int unsigned STAT_UNLOCKED_BIT = 0;
  localparam int unsigned STAT_LAST_LSB     = 16;

  // ---------------------------------------------------------------
  // conversion channel that produced a result
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CHAN_HS_TIA,
    CHAN_AUX_GAIN1,
    CHAN_OTHER
  } arogc_chan_t;

endpackage

// ===== core/arogc_corrector.sv
// two-stage offset and gain correction of one conversion result word
`timescale 1ns/100ps
`default_nettype none
module arogc_corrector
  import arogc_pkg::*;
#(
  parameter int unsigned W = arogc_pkg::WORD_W
) (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // raw result and its trims
  input  wire logic                        raw_valid,
  input  wire logic [W-1:0]                raw_word,
  input  wire logic [arogc_pkg::FIELD_W-1:0] offset_trim,
  input  wire logic [arogc_pkg::FIELD_W-1:0] gain_trim,
  // corrected result
  output logic                             corr_valid,
  output logic [W-1:0]                     corr_word
);

  import arogc_pkg::*;

  logic                     s1_valid_ff;
  logic signed [SUM_W-1:0]  s1_sum_ff;
  logic [FIELD_W-1:0]       s1_gain_ff;
  logic signed [SUM_W-1:0]  nxt_s1_sum;
  logic signed [PROD_W-1:0] prod;
  logic signed [PROD_W-1:0] rounded;
  logic signed [PROD_W-1:0] scaled;
  logic [W-1:0]             nxt_out_word;

  // ---------------------------------------------------------------
  // stage 1: offset in quarter steps
  // ---------------------------------------------------------------
  // result is widened by two fraction bits so that one offset step is a quarter of its lsb
  always_comb begin
    nxt_s1_sum = $signed({2'b00, raw_word, 2'b00})
               + $signed({{(SUM_W-FIELD_W){offset_trim[FIELD_W-1]}}, offset_trim}); // R2 R3 R4 R5
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_valid_ff <= 1'b0;
      s1_sum_ff   <= '0;
      s1_gain_ff  <= RST_GAIN_TRIM;
    end else begin
      s1_valid_ff <= raw_valid;
      s1_sum_ff   <= nxt_s1_sum;
      s1_gain_ff  <= gain_trim;
    end
  end

  // ---------------------------------------------------------------
  // stage 2: gain, rounding and clamping
  // ---------------------------------------------------------------
  // gain is an unsigned 1.14 factor; bit 14 carries unity weight, so 0x4000 is exactly one
  always_comb begin
    prod    = PROD_W'(s1_sum_ff) * $signed({1'b0, s1_gain_ff}); // R7 R8 R9 R10 R13
    rounded = prod + $signed(ROUND_HALF);
    scaled  = rounded >>> (FRAC_GAIN + FRAC_OFF);
    if (s1_gain_ff == GAIN_ILLEGAL) begin
      nxt_out_word = WORD_MIN; // R11
    end else if (scaled < 0) begin
      nxt_out_word = WORD_MIN;
    end else if (scaled > $signed({{(PROD_W-W){1'b0}}, WORD_MAX})) begin
      nxt_out_word = WORD_MAX;
    end else begin
      nxt_out_word = scaled[W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      corr_valid <= 1'b0;
      corr_word  <= '0;
    end else begin
      corr_valid <= s1_valid_ff;
      corr_word  <= nxt_out_word;
    end
  end

endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the conversion result calibration register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import arogc_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic               pclk;
  logic               presetn;
  logic [ADDR_W-1:0]  paddr;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [DATA_W-1:0]  pwdata;
  logic [STRB_W-1:0]  pstrb;
  logic [DATA_W-1:0]  prdata;
  logic               pready;
  logic               pslverr;
  logic               conv_valid;
  logic [WORD_W-1:0]  conversion_result_word;
  arogc_chan_t        conv_channel;
  logic               corrected_valid;
  logic [WORD_W-1:0]  corrected_word;
  logic               cal_unlocked;
  int                 errors;
  int                 num_checks;
  int                 cycles;
  logic [DATA_W-1:0]  rd;
  logic               err;
  // offset, gain and raw code for each high-speed case
  logic [14:0]        t_off[13]  = '{15'h0000, 15'h3FFF, 15'h0001, 15'h4000, 15'h7FFF, 15'h4000, 15'h0000,
                                     15'h0000, 15'h0000, 15'h0000, 15'h0000, 15'h0000, 15'h0100};
  logic [14:0]        t_gain[13] = '{15'h4000, 15'h4000, 15'h7FFF, 15'h4000, 15'h4000, 15'h4000, 15'h7FFF,
                                     15'h7FFF, 15'h2000, 15'h4001, 15'h3FFF, 15'h0001, 15'h0000};
  logic [15:0]        t_raw[13]  = '{16'h03E8, 16'h0000, 16'h0064, 16'h1388, 16'h000A, 16'h000A, 16'h03E8,
                                     16'hFFFF, 16'h03E9, 16'hFFF0, 16'hFFFF, 16'hFFFF, 16'h1234};

  arogc_cal_bank #(.W(WORD_W)) i_dut (
    .pclk                   (pclk),
    .presetn                (presetn),
    .paddr                  (paddr),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .pwdata                 (pwdata),
    .pstrb                  (pstrb),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .conv_valid             (conv_valid),
    .conversion_result_word (conversion_result_word),
    .conv_channel           (conv_channel),
    .corrected_valid        (corrected_valid),
    .corrected_word         (corrected_word),
    .cal_unlocked           (cal_unlocked)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // reference arithmetic: quarter-lsb signed offset, 1.14 gain, round half up
  // ---------------------------------------------------------------
  function automatic logic [15:0] model(input logic [15:0] raw, input logic [14:0] off, input logic [14:0] g);
    longint s;
    longint p;
    s = longint'(raw) * 4 + (off[14] ? longint'(off) - 32768 : longint'(off));
    if (g == 15'h0000) return 16'h0000;
    p = (s * longint'(g) + 32768) >>> 16;
    if (p < 0) return 16'h0000;
    if (p > 65535) return 16'hFFFF;
    return p[15:0];
  endfunction

  // ---------------------------------------------------------------
  // apb master and result tasks
  // ---------------------------------------------------------------
  task automatic apb_xfer(input logic [15:0] a, input logic w, input logic [31:0] wd,
                          output logic [31:0] d, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic apb_wr(input logic [15:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb_xfer(a, 1'b1, wd, d, e);
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb_xfer(a, 1'b0, 32'h0000_0000, d, e);
    `CHK(nm, exp, d)
    `CHK("slave error", 1'b0, e)
  endtask

  task automatic conv_chk(input arogc_chan_t ch, input logic [15:0] raw, input logic [15:0] exp);
    int n;
    @(posedge pclk);
    conv_valid             <= 1'b1;
    conv_channel           <= ch;
    conversion_result_word <= raw;
    @(posedge pclk);
    conv_valid <= 1'b0;
    n = 0;
    while (corrected_valid !== 1'b1 && n < 6) begin
      @(negedge pclk);
      n++;
    end
    `CHK("corrected valid", 1'b1, corrected_valid)
    `CHK("corrected word", exp, corrected_word)
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // a full run needs well under 2000 cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    errors = 0;
    num_checks = 0;
    cycles = 0;
    presetn = 1'b0;
    paddr = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = '0;
    pstrb = 4'hF;
    conv_valid = 1'b0;
    conversion_result_word = '0;
    conv_channel = CHAN_OTHER;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("hs offset reset", ADDR_HS_OFFSET_TRIM, 32'h0000_0000);
    rd_chk("aux offset reset", ADDR_AUX_OFFSET_TRIM, 32'h0000_0000);
    rd_chk("gain reset", ADDR_HS_GAIN_TRIM, 32'h0000_4000);
    rd_chk("lock reset", ADDR_WRITE_LOCK, 32'h0000_0000);
    conv_chk(CHAN_HS_TIA, 16'hABCD, 16'hABCD);
    apb_wr(ADDR_HS_GAIN_TRIM, 32'h0000_1234);
    rd_chk("gain while locked", ADDR_HS_GAIN_TRIM, 32'h0000_4000);
    apb_wr(ADDR_WRITE_LOCK, UNLOCK_KEY);
    @(negedge pclk);
    `CHK("unlocked", 1'b1, cal_unlocked)
    rd_chk("lock value", ADDR_WRITE_LOCK, UNLOCK_KEY);
    apb_wr(ADDR_HS_OFFSET_TRIM, 32'hFFFF_FFFF);
    rd_chk("hs offset upper bits", ADDR_HS_OFFSET_TRIM, 32'h0000_7FFF);
    apb_wr(ADDR_HS_GAIN_TRIM, 32'hFFFF_8000);
    rd_chk("gain upper bits", ADDR_HS_GAIN_TRIM, 32'h0000_0000);
    for (int i = 0; i < 13; i++) begin
      apb_wr(ADDR_HS_OFFSET_TRIM, {17'h0, t_off[i]});
      apb_wr(ADDR_HS_GAIN_TRIM, {17'h0, t_gain[i]});
      conv_chk(CHAN_HS_TIA, t_raw[i], model(t_raw[i], t_off[i], t_gain[i]));
    end
    // hs gain is now zero: aux and other results must not see it
    apb_wr(ADDR_AUX_OFFSET_TRIM, 32'h0000_4000);
    conv_chk(CHAN_AUX_GAIN1, 16'h1388, model(16'h1388, 15'h4000, 15'h4000));
    conv_chk(CHAN_OTHER, 16'h1234, 16'h1234);
    rd_chk("status unlocked", ADDR_CAL_STATUS, 32'h1234_0001);
    apb_wr(ADDR_AUX_OFFSET_TRIM, 32'h0000_0004);
    conv_chk(CHAN_AUX_GAIN1, 16'h0010, 16'h0011);
    apb_xfer(16'h2300, 1'b0, 32'h0, rd, err);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rd)
    apb_wr(ADDR_WRITE_LOCK, 32'h0000_0001);
    @(negedge pclk);
    `CHK("relocked", 1'b0, cal_unlocked)
    apb_wr(ADDR_HS_GAIN_TRIM, 32'h0000_4000);
    rd_chk("gain after relock", ADDR_HS_GAIN_TRIM, 32'h0000_0000);
    apb_wr(ADDR_HS_OFFSET_TRIM, 32'h0000_0000);
    rd_chk("hs offset after relock", ADDR_HS_OFFSET_TRIM, 32'h0000_0100);
    apb_wr(ADDR_AUX_OFFSET_TRIM, 32'h0000_0000);
    rd_chk("aux offset after relock", ADDR_AUX_OFFSET_TRIM, 32'h0000_0004);
    rd_chk("status locked", ADDR_CAL_STATUS, 32'h0011_0000);
    close_out();
  end
endmodule
`default_nettype wire
